// *** rtl/lpmc_pkg.sv ***
// Overview of operation
// - Four low-power modes entered by software request
// - Sleep stops core clock until interrupt
// - Clocked peripherals run, their interrupts wake
// - Deep-sleep powers flash down, gates unkept peripherals
// - Listed peripherals may stay clocked in deep-sleep
// - Listed sources wake from deep-sleep
// - DMA served in deep-sleep without waking
// - Deep-sleep keeps SRAM; unretained banks stay active
// - Power-down stops converter, flash and clocks except the DMA clock and kept peripheral clocks
// - Power-down keeps only serial 3, RTC, timer, comparator
// - Power-down wakes only on listed sources
// - Power-down retains state; unretained banks shut down
// - Deep power-down keeps RTC, reset, wake pins, timer
// - Deep power-down exits on reset, alarm, pins, timer
// - One-hertz alarm flag raises RTC wake request
// - Deep power-down tri-states all functional pins
// - Brownout gives interrupt or reset as configured
// - Group GPIO interrupts wake sleep, deep-sleep, power-down
package lpmc_pkg;
   typedef enum logic [2:0] {
      LPMC_ACTIVE, LPMC_SLEEP, LPMC_DSLEEP, LPMC_PDOWN, LPMC_DPD, LPMC_WAKE
   } lpmc_state_t;
   typedef enum logic [1:0] {
      LPMC_REQ_SLEEP, LPMC_REQ_DSLEEP, LPMC_REQ_PDOWN, LPMC_REQ_DPD
   } lpmc_mode_t;
   // Peripheral keep-clock bits
   localparam int LPMC_NPER = 18;
   localparam int P_USB_FS = 0;
   localparam int P_USB_HS = 1;
   localparam int P_SER0 = 2;
   localparam int P_SER3 = 5;
   localparam int P_SER7 = 9;
   localparam int P_HSSPI = 10;
   localparam int P_UTICK = 11;
   localparam int P_WDOG = 12;
   localparam int P_RTC = 13;
   localparam int P_OSTMR = 14;
   localparam int P_TIMERS = 15;
   localparam int P_COMP = 16;
   localparam int P_BROWN = 17;
   localparam logic [LPMC_NPER-1:0] LPMC_DSLEEP_ALLOW = 18'h3ffff;
   localparam logic [LPMC_NPER-1:0] LPMC_PDOWN_ALLOW = 18'h16020;
   // Wake source bits
   localparam int LPMC_NWAKE = 12;
   localparam int W_PINT = 0;
   localparam int W_GINT = 1;
   localparam int W_OSTMR = 2;
   localparam int W_TIMERS = 3;
   localparam int W_UTICK = 4;
   localparam int W_RTC = 5;
   localparam int W_WDOG = 6;
   localparam int W_BROWN = 7;
   localparam int W_USB = 8;
   localparam int W_SERIAL = 9;
   localparam int W_COMP = 10;
   localparam int W_PLU = 11;
   localparam logic [LPMC_NWAKE-1:0] LPMC_DSLEEP_WAKE = 12'hfff;
   localparam logic [LPMC_NWAKE-1:0] LPMC_PDOWN_WAKE = 12'h626;
   localparam int LPMC_NBANK = 5;
   localparam int LPMC_NWPIN = 4;
   // Flash settle time on wake
   localparam int LPMC_FLASH_NS = 1000;
   localparam int LPMC_CLK_NS = 100;
   localparam int LPMC_FLASH_CYC = (LPMC_FLASH_NS + LPMC_CLK_NS - 1) / LPMC_CLK_NS;
   localparam logic [7:0] LPMC_FLASH_CNT = 8'(LPMC_FLASH_CYC);
endpackage

// *** rtl/lpmc_sync_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface lpmc_sync_if;
   logic [3:0] wake_pin;
   logic rtc_alarm;
   logic brown_low;
   modport src(output wake_pin, output rtc_alarm, output brown_low);
   modport dst(input wake_pin, input rtc_alarm, input brown_low);
endinterface
`default_nettype wire

// *** rtl/lpmc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module lpmc_sync (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [5:0] i_async,
   lpmc_sync_if.src o_sync
);
   logic [5:0] meta_ff;
   logic [5:0] sync_ff;
   // First stage feeds only the second
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= 6'h00;
         sync_ff <= 6'h00;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end
   assign o_sync.wake_pin = sync_ff[3:0];
   assign o_sync.rtc_alarm = sync_ff[4];
   assign o_sync.brown_low = sync_ff[5];
endmodule
`default_nettype wire

// *** rtl/lpmc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module lpmc_top (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_sleep_req,
   input wire lpmc_pkg::lpmc_mode_t i_mode,
   input wire logic [lpmc_pkg::LPMC_NPER-1:0] i_keep_clk,
   input wire logic [lpmc_pkg::LPMC_NBANK-1:0] i_bank_retain,
   input wire logic i_ostmr_en,
   input wire logic i_irq_any,
   input wire logic [lpmc_pkg::LPMC_NWAKE-1:0] i_wake_src,
   input wire logic i_dma_req,
   input wire logic i_one_hz_alarm_flag,
   input wire logic i_ostmr_timeout,
   input wire logic [lpmc_pkg::LPMC_NWPIN-1:0] i_wake_pin,
   input wire logic i_brown_low,
   input wire logic i_brown_reset_en,
   output logic o_core_clk_en,
   output logic [lpmc_pkg::LPMC_NPER-1:0] o_per_clk_en,
   output logic o_flash_pwr,
   output logic o_dcdc_en,
   output logic [lpmc_pkg::LPMC_NBANK-1:0] o_bank_retain,
   output logic [lpmc_pkg::LPMC_NBANK-1:0] o_bank_shut,
   output logic o_dma_clk_en,
   output logic o_main_pwr,
   output logic o_ostmr_pwr,
   output logic o_pins_oe_n,
   output logic o_rtc_wake_irq,
   output logic o_brown_irq,
   output logic o_sys_reset,
   output logic o_core_run,
   output lpmc_pkg::lpmc_state_t o_state
);
   import lpmc_pkg::*;

   logic [1:0] rst_sync_ff;
   logic rst_n;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Pin and RTC-domain levels come from outside this clock
   lpmc_sync_if sif ();
   lpmc_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_async({i_brown_low, i_one_hz_alarm_flag, i_wake_pin}),
      .o_sync(sif.src)
   );

   lpmc_state_t state_ff, nxt_state;
   logic [7:0] wake_cnt_ff;
   logic [LPMC_NPER-1:0] keep_ff;
   logic brown_evt;
   logic wake_now;
   logic dpd_exit;
   logic [LPMC_NPER-1:0] entry_keep;
   logic in_wake;

   assign brown_evt = sif.brown_low;
   assign dpd_exit = sif.rtc_alarm || (|sif.wake_pin) ||
                     (i_ostmr_en && i_ostmr_timeout);

   always_comb begin
      case (state_ff)
         LPMC_SLEEP: wake_now = i_irq_any || i_wake_src[W_GINT];
         LPMC_DSLEEP: wake_now = |(i_wake_src & LPMC_DSLEEP_WAKE);
         LPMC_PDOWN: wake_now = |(i_wake_src & LPMC_PDOWN_WAKE);
         default: wake_now = 1'b0;
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         LPMC_ACTIVE: begin
            if (i_sleep_req) begin
               case (i_mode)
                  LPMC_REQ_SLEEP: nxt_state = LPMC_SLEEP;
                  LPMC_REQ_DSLEEP: nxt_state = LPMC_DSLEEP;
                  LPMC_REQ_PDOWN: nxt_state = LPMC_PDOWN;
                  default: nxt_state = LPMC_DPD;
               endcase
            end
         end
         LPMC_SLEEP: begin
            if (wake_now) begin
               nxt_state = LPMC_ACTIVE;
            end
         end
         LPMC_DSLEEP, LPMC_PDOWN: begin
            if (wake_now) begin
               nxt_state = LPMC_WAKE;
            end
         end
         LPMC_WAKE: begin
            if (wake_cnt_ff == 8'h00) begin
               nxt_state = LPMC_ACTIVE;
            end
         end
         LPMC_DPD: begin
            if (dpd_exit) begin
               nxt_state = LPMC_ACTIVE;
            end
         end
         default: nxt_state = LPMC_ACTIVE;
      endcase
      // Brownout reset outranks every mode, so the outputs follow it at once
      if (brown_evt && i_brown_reset_en) begin
         nxt_state = LPMC_ACTIVE;
      end
   end

   // Deep power-down exit is a full reset, as the chip lost power
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= LPMC_ACTIVE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_ff <= 8'h00;
      end else if (state_ff != LPMC_WAKE) begin
         wake_cnt_ff <= LPMC_FLASH_CNT - 8'h01;
      end else if (wake_cnt_ff != 8'h00) begin
         wake_cnt_ff <= wake_cnt_ff - 8'h01;
      end
   end

   always_comb begin
      case (i_mode)
         LPMC_REQ_DSLEEP: entry_keep = i_keep_clk & LPMC_DSLEEP_ALLOW;
         LPMC_REQ_PDOWN: entry_keep = i_keep_clk & LPMC_PDOWN_ALLOW;
         default: entry_keep = i_keep_clk;
      endcase
   end

   // Keep mask is captured at entry so later writes cannot widen it
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         keep_ff <= '0;
      end else if (state_ff == LPMC_ACTIVE && i_sleep_req) begin
         keep_ff <= entry_keep;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_core_clk_en <= 1'b1;
         o_core_run <= 1'b1;
         o_per_clk_en <= '1;
         o_flash_pwr <= 1'b1;
         o_dcdc_en <= 1'b1;
         o_main_pwr <= 1'b1;
         o_pins_oe_n <= 1'b0;
      end else begin
         o_core_clk_en <= (nxt_state == LPMC_ACTIVE);
         o_core_run <= (nxt_state == LPMC_ACTIVE);
         case (nxt_state)
            // Entry edge takes the mask directly, as keep_ff loads on that same edge
            LPMC_SLEEP, LPMC_DSLEEP, LPMC_PDOWN: begin
               o_per_clk_en <= (state_ff == LPMC_ACTIVE) ? entry_keep : keep_ff;
            end
            LPMC_DPD: o_per_clk_en <= '0;
            default: o_per_clk_en <= '1;
         endcase
         o_flash_pwr <= !(nxt_state inside {LPMC_DSLEEP, LPMC_PDOWN, LPMC_DPD});
         o_dcdc_en <= !(nxt_state inside {LPMC_PDOWN, LPMC_DPD});
         o_main_pwr <= (nxt_state != LPMC_DPD);
         o_pins_oe_n <= (nxt_state == LPMC_DPD);
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_bank_retain <= '0;
         o_bank_shut <= '0;
         o_ostmr_pwr <= 1'b1;
         o_dma_clk_en <= 1'b1;
      end else begin
         o_bank_retain <= (nxt_state == LPMC_ACTIVE) ? '0 : i_bank_retain;
         o_bank_shut <= (nxt_state inside {LPMC_PDOWN, LPMC_DPD}) ?
                        ~i_bank_retain : '0;
         o_ostmr_pwr <= (nxt_state != LPMC_DPD) || i_ostmr_en;
         o_dma_clk_en <= (nxt_state != LPMC_DSLEEP) || i_dma_req;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rtc_wake_irq <= 1'b0;
         o_brown_irq <= 1'b0;
         o_sys_reset <= 1'b0;
         o_state <= LPMC_ACTIVE;
      end else begin
         o_rtc_wake_irq <= sif.rtc_alarm;
         o_brown_irq <= brown_evt && !i_brown_reset_en;
         o_sys_reset <= (brown_evt && i_brown_reset_en) ||
                        (state_ff == LPMC_DPD && dpd_exit);
         o_state <= nxt_state;
      end
   end

   assign in_wake = (state_ff == LPMC_WAKE);

   a_sleep_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_SLEEP && !i_irq_any && !i_wake_src[W_GINT] && !brown_evt)
      |=> !o_core_clk_en) else $error("core clock on in sleep");
   a_sleep_wake: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_SLEEP && i_irq_any) |=> o_core_run)
      else $error("sleep not left on interrupt");
   a_flash_off: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff inside {LPMC_DSLEEP, LPMC_PDOWN}) |-> !o_flash_pwr)
      else $error("flash powered in deep mode");
   a_pdown_keep: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_PDOWN) |-> ((o_per_clk_en & ~LPMC_PDOWN_ALLOW) == '0))
      else $error("forbidden clock in power-down");
   a_pdown_dcdc: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_PDOWN) |-> !o_dcdc_en) else $error("converter on");
   a_pdown_nowake: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_PDOWN && !brown_evt &&
       (i_wake_src & LPMC_PDOWN_WAKE) == '0) |=> state_ff == LPMC_PDOWN)
      else $error("power-down left without source");
   a_wake_delay: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      ($rose(state_ff == LPMC_WAKE) && !brown_evt) |-> !o_core_run [*2])
      else $error("core released before flash ready");
   a_dpd_pins: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_DPD) |-> (o_pins_oe_n && !o_main_pwr))
      else $error("pins driven in deep power-down");
   a_dpd_exit: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_DPD && sif.rtc_alarm) |=> o_sys_reset)
      else $error("no exit on alarm");
   a_brown_irq: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (brown_evt && !i_brown_reset_en) |=> (o_brown_irq && !o_sys_reset))
      else $error("brownout response wrong");
   // A wake that ends early would hand the core a flash that is not yet ready
   a_wake_len: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_ACTIVE && $past(state_ff) == LPMC_WAKE && !$past(brown_evt))
      |-> $past(in_wake, LPMC_FLASH_CYC)) else $error("flash settle cut short");
   a_dma_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_DSLEEP) |-> (o_dma_clk_en == $past(i_dma_req)))
      else $error("dma clock wrong in deep-sleep");
   a_bank_dsleep: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_DSLEEP) |-> (o_bank_shut == '0 &&
       o_bank_retain == $past(i_bank_retain))) else $error("bank state wrong in deep-sleep");
   a_bank_pdown: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_PDOWN) |-> (o_bank_shut == ~$past(i_bank_retain)))
      else $error("bank not shut in power-down");
   a_rtc_irq: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      sif.rtc_alarm |=> o_rtc_wake_irq) else $error("alarm raised no wake request");
   a_ostmr_dpd: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
      (state_ff == LPMC_DPD) |-> (o_ostmr_pwr == $past(i_ostmr_en)))
      else $error("timer power wrong in deep power-down");
   c_sleep: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_ff == LPMC_SLEEP ##1 state_ff == LPMC_ACTIVE);
   c_dsleep: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_ff == LPMC_DSLEEP ##1 state_ff == LPMC_WAKE);
   c_pdown: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_ff == LPMC_PDOWN ##1 state_ff == LPMC_WAKE);
   c_dpd: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      state_ff == LPMC_DPD ##1 state_ff == LPMC_ACTIVE);
endmodule
`default_nettype wire

// *** bench/lpmc_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module lpmc_core_model (
   input wire logic i_ref_clk,
   output logic o_sleep_req,
   output var lpmc_pkg::lpmc_mode_t o_mode,
   output logic [lpmc_pkg::LPMC_NPER-1:0] o_keep_clk
);
   import lpmc_pkg::*;
   initial begin
      o_sleep_req = 1'b0;
      o_mode = LPMC_REQ_SLEEP;
      o_keep_clk = '0;
   end
   // Config settles a full cycle ahead of the request
   task automatic do_request(input lpmc_mode_t m, input logic [LPMC_NPER-1:0] k);
      @(posedge i_ref_clk);
      #1;
      o_mode = m;
      o_keep_clk = k;
      @(posedge i_ref_clk);
      #1;
      o_sleep_req = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_sleep_req = 1'b0;
      // Software may rewrite config once taken, so the lines move
      o_mode = lpmc_mode_t'(~m);
      o_keep_clk = ~k;
   endtask
endmodule
`default_nettype wire

// *** bench/low_power_mode_controller_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_controller_tb_top;
   import lpmc_pkg::*;
   logic i_ref_clk, i_rst_n, i_sleep_req, i_ostmr_en, i_irq_any, i_dma_req;
   logic i_one_hz_alarm_flag, i_ostmr_timeout, i_brown_low, i_brown_reset_en;
   logic [LPMC_NWPIN-1:0] i_wake_pin;
   logic [LPMC_NWAKE-1:0] i_wake_src;
   logic [LPMC_NPER-1:0] i_keep_clk, o_per_clk_en, kp;
   logic [LPMC_NBANK-1:0] i_bank_retain, o_bank_retain, o_bank_shut;
   lpmc_mode_t i_mode;
   lpmc_state_t o_state;
   logic o_core_clk_en, o_flash_pwr, o_dcdc_en, o_dma_clk_en, o_main_pwr, o_ostmr_pwr;
   logic o_pins_oe_n, o_rtc_wake_irq, o_brown_irq, o_sys_reset, o_core_run;
   logic seen_irq, seen_rst, clr_seen, allow;
   int fails, checks_done;
   lpmc_top DUT (.i_ref_clk, .i_rst_n, .i_sleep_req, .i_mode, .i_keep_clk,
      .i_bank_retain, .i_ostmr_en, .i_irq_any, .i_wake_src, .i_dma_req,
      .i_one_hz_alarm_flag, .i_ostmr_timeout, .i_wake_pin, .i_brown_low,
      .i_brown_reset_en, .o_core_clk_en, .o_per_clk_en, .o_flash_pwr, .o_dcdc_en,
      .o_bank_retain, .o_bank_shut, .o_dma_clk_en, .o_main_pwr, .o_ostmr_pwr,
      .o_pins_oe_n, .o_rtc_wake_irq, .o_brown_irq, .o_sys_reset, .o_core_run, .o_state);
   lpmc_core_model u_core (.i_ref_clk, .o_sleep_req(i_sleep_req), .o_mode(i_mode),
      .o_keep_clk(i_keep_clk));
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   // Pulses are caught here so a one-cycle event is never missed
   always @(posedge i_ref_clk) begin
      seen_irq <= !clr_seen && (seen_irq || o_rtc_wake_irq);
      seen_rst <= !clr_seen && (seen_rst || o_sys_reset);
   end
   task automatic step(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("fails %0d checks_done %0d", fails, checks_done);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         fails++;
      end
   endtask
   task automatic wait_st(input lpmc_state_t s);
      int n;
      n = 0;
      while (o_state !== s && n < 200) begin
         step(1);
         n++;
      end
      chk("state", s, o_state);
      if (n == 200) report_and_stop();
   endtask
   // Core must stay held while flash settles
   task automatic wake_chk();
      step(2);
      chk("core_run", 0, o_core_run);
      chk("flash", 1, o_flash_pwr);
      step(LPMC_FLASH_CYC - 2);
      chk("core_run", 0, o_core_run);
      step(1);
      chk("core_run", 1, o_core_run);
      wait_st(LPMC_ACTIVE);
      chk("flash", 1, o_flash_pwr);
      chk("core_clk", 1, o_core_clk_en);
   endtask
   initial begin
      {i_rst_n, i_ostmr_en, i_irq_any, i_dma_req, i_one_hz_alarm_flag} = '0;
      {i_ostmr_timeout, i_brown_low, i_brown_reset_en} = '0;
      clr_seen = 1'b1;
      i_wake_pin = '0;
      i_wake_src = '0;
      i_bank_retain = 5'h05;
      kp = 18'h2a5a5;
      fails = 0;
      checks_done = 0;
      repeat (16) @(posedge i_ref_clk);
      #1;
      i_rst_n = 1'b1;
      step(3);
      u_core.do_request(LPMC_REQ_SLEEP, 18'h00c01);
      chk("state", LPMC_SLEEP, o_state);
      chk("core_clk", 0, o_core_clk_en);
      chk("per_clk", 18'h00c01, o_per_clk_en);
      step(5);
      chk("state", LPMC_SLEEP, o_state);
      i_irq_any = 1'b1;
      wait_st(LPMC_ACTIVE);
      i_irq_any = 1'b0;
      u_core.do_request(LPMC_REQ_DSLEEP, kp);
      chk("dma_clk", 0, o_dma_clk_en);
      i_dma_req = 1'b1;
      step(2);
      chk("dma_clk", 1, o_dma_clk_en);
      chk("state", LPMC_DSLEEP, o_state);
      i_dma_req = 1'b0;
      u_core.do_request(LPMC_REQ_PDOWN, kp);
      chk("state", LPMC_DSLEEP, o_state);
      for (int m = 1; m < 3; m++) begin
         for (int w = 0; w < LPMC_NWAKE; w++) begin
            // First pass is already in deep-sleep, so its request is ignored
            u_core.do_request(lpmc_mode_t'(m), kp);
            chk("flash", 0, o_flash_pwr);
            chk("core_clk", 0, o_core_clk_en);
            chk("dcdc", m == 1, o_dcdc_en);
            chk("per_clk", kp & (m == 1 ? LPMC_DSLEEP_ALLOW : LPMC_PDOWN_ALLOW),
               o_per_clk_en);
            chk("shut", m == 1 ? 5'h00 : 5'(~i_bank_retain), o_bank_shut);
            chk("retain", i_bank_retain, o_bank_retain);
            allow = m == 1 ? LPMC_DSLEEP_WAKE[w] : LPMC_PDOWN_WAKE[w];
            i_wake_src = 12'(1 << w);
            if (allow) begin
               wake_chk();
            end else begin
               step(4);
               chk("state", LPMC_PDOWN, o_state);
               i_wake_src = 12'(1 << W_GINT);
               wake_chk();
            end
            i_wake_src = '0;
         end
      end
      for (int c = 0; c < 4; c++) begin
         // Last pass leaves the timer off, so its time-out must not wake
         i_ostmr_en = (c != 3);
         u_core.do_request(LPMC_REQ_DPD, kp);
         chk("pins_oe_n", 1, o_pins_oe_n);
         chk("main_pwr", 0, o_main_pwr);
         chk("ostmr_pwr", c != 3, o_ostmr_pwr);
         i_wake_src = '1;
         i_irq_any = 1'b1;
         step(5);
         chk("state", LPMC_DPD, o_state);
         i_wake_src = '0;
         i_irq_any = 1'b0;
         clr_seen = 1'b1;
         step(1);
         clr_seen = 1'b0;
         if (c == 0) i_one_hz_alarm_flag = 1'b1;
         if (c == 1) i_wake_pin = 4'h8;
         if (c >= 2) i_ostmr_timeout = 1'b1;
         if (c == 3) begin
            step(3);
            chk("state", LPMC_DPD, o_state);
            i_wake_pin = 4'h1;
         end
         wait_st(LPMC_ACTIVE);
         step(1);
         chk("sys_reset", 1, seen_rst);
         chk("pins_oe_n", 0, o_pins_oe_n);
         if (c == 0) chk("rtc_irq", 1, seen_irq);
         {i_one_hz_alarm_flag, i_ostmr_timeout} = '0;
         i_wake_pin = '0;
         step(4);
      end
      i_brown_low = 1'b1;
      step(6);
      chk("brown_irq", 1, o_brown_irq);
      chk("sys_reset", 0, o_sys_reset);
      i_brown_reset_en = 1'b1;
      step(3);
      chk("sys_reset", 1, o_sys_reset);
      u_core.do_request(LPMC_REQ_SLEEP, kp);
      chk("state", LPMC_ACTIVE, o_state);
      i_brown_low = 1'b0;
      step(6);
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge i_ref_clk);
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
